// [hw/acbu_pkg.sv]
// Package: codes, register map and carriers of the accumulator compare branch unit
package acbu_pkg;
    localparam int BYTE_W = 8;
    localparam int PKT_BYTES = 9;
    localparam int OUT_PORTS = 8;
    localparam int ADC_W = 16;
    localparam int IRQ_W = 4;
    localparam int PROG_CMD_W = 24;

    localparam logic [7:0] OP_INPUT_READ = 8'h0f;
    localparam logic [7:0] OP_ARITH = 8'h13;
    localparam logic [7:0] OP_COMPARE = 8'h14;
    localparam logic [7:0] OP_COND_JUMP = 8'h15;

    localparam logic [7:0] STAT_OK = 8'h64;
    localparam logic [7:0] STAT_BAD_CSUM = 8'h01;
    localparam logic [7:0] STAT_BAD_CMD = 8'h02;
    localparam logic [7:0] STAT_BAD_VALUE = 8'h04;

    localparam logic [7:0] BANK_ANALOG = 8'h01;
    localparam logic [7:0] BANK_OUT_STATE = 8'h02;
    localparam logic [7:0] PORT_ANALOG = 8'h00;

    localparam logic [7:0] ALU_ADD = 8'h00;
    localparam logic [7:0] ALU_SUB = 8'h01;
    localparam logic [7:0] ALU_MUL = 8'h02;
    localparam logic [7:0] ALU_DIV = 8'h03;
    localparam logic [7:0] ALU_MOD = 8'h04;
    localparam logic [7:0] ALU_AND = 8'h05;
    localparam logic [7:0] ALU_OR = 8'h06;
    localparam logic [7:0] ALU_XOR = 8'h07;
    localparam logic [7:0] ALU_NOT = 8'h08;
    localparam logic [7:0] ALU_LOAD = 8'h09;

    localparam logic [7:0] COND_ZE = 8'h00;
    localparam logic [7:0] COND_NZ = 8'h01;
    localparam logic [7:0] COND_EQ = 8'h02;
    localparam logic [7:0] COND_NE = 8'h03;
    localparam logic [7:0] COND_GT = 8'h04;
    localparam logic [7:0] COND_GE = 8'h05;
    localparam logic [7:0] COND_LT = 8'h06;
    localparam logic [7:0] COND_LE = 8'h07;
    localparam logic [7:0] COND_TIMEOUT = 8'h08;
    localparam logic [7:0] COND_ALARM = 8'h09;
    localparam logic [7:0] COND_DEVIATION = 8'h0a;
    localparam logic [7:0] COND_POSITION = 8'h0b;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ACC = 12'h008;
    localparam logic [11:0] REG_IRQ_STAT = 12'h00c;
    localparam logic [11:0] REG_IRQ_MASK = 12'h010;
    localparam logic [11:0] REG_PROG_ADDR = 12'h014;
    localparam logic [11:0] REG_PROG_CMD = 12'h018;
    localparam logic [11:0] REG_PROG_VAL = 12'h01c;

    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_PC_LSB = 8;
    localparam int ST_FLAG_LSB = 16;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CSUM = 1;
    localparam int IRQ_END = 2;
    localparam int IRQ_JUMP = 3;

    typedef enum logic {ACBU_IDLE, ACBU_REPLY} acbu_st_e;

    typedef struct packed {
        logic [7:0] instr;
        logic [7:0] kind;
        logic [7:0] bank;
        logic [31:0] value;
    } acbu_cmd_s;

    typedef struct packed {
        logic eq;
        logic gt;
        logic lt;
    } acbu_flags_s;

    typedef struct packed {
        logic timeout_error_flag;
        logic external_alarm_flag;
        logic deviation_error_flag;
        logic position_error_flag;
    } acbu_err_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } acbu_apb_req_s;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } acbu_apb_rsp_s;

    function automatic logic [7:0] acbu_csum(input logic [PKT_BYTES-2:0][7:0] b);
        logic [7:0] s;
        s = '0;
        for (int i = 0; i < PKT_BYTES-1; i++) begin
            s = s + b[i];
        end
        return s;
    endfunction
endpackage

// [hw/acbu_alu.sv]
// Accumulator arithmetic and signed compare, purely combinational
`timescale 1ns/1ps
module acbu_alu import acbu_pkg::*; (
    input wire logic [31:0] acc_i,
    input wire logic [31:0] opd_i,
    input wire logic [7:0] op_i,
    output logic [31:0] res_o,
    output logic ok_o,
    output acbu_flags_s flags_o
);
    logic signed [31:0] a;
    logic signed [31:0] b;
    logic signed [63:0] prod;

    always_comb begin
        a = acc_i;
        b = opd_i;
        prod = a * b;
        ok_o = 1'b1;
        res_o = acc_i;
        case (op_i)
            ALU_ADD: res_o = 32'(a + b);
            ALU_SUB: res_o = 32'(a - b);
            ALU_MUL: res_o = prod[31:0];
            ALU_DIV: begin
                // Division by zero leaves the accumulator as it was
                if (b != '0) res_o = 32'(a / b);
                else ok_o = 1'b0;
            end
            ALU_MOD: begin
                if (b != '0) res_o = 32'(a % b);
                else ok_o = 1'b0;
            end
            ALU_AND: res_o = acc_i & opd_i;
            ALU_OR: res_o = acc_i | opd_i;
            ALU_XOR: res_o = acc_i ^ opd_i;
            ALU_NOT: res_o = ~acc_i;
            ALU_LOAD: res_o = opd_i;
            default: ok_o = 1'b0;
        endcase
        flags_o.eq = (a == b);
        flags_o.gt = (a > b);
        flags_o.lt = (a < b);
    end
endmodule

// [hw/acbu_pkt_rx.sv]
// Packet receiver: gathers nine command bytes and checks the checksum
`timescale 1ns/1ps
module acbu_pkt_rx import acbu_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic take_i,
    output logic ready_o,
    output logic pkt_valid_o,
    output logic [7:0] addr_o,
    output acbu_cmd_s pkt_o,
    output logic csum_ok_o
);
    typedef struct packed {
        logic [3:0] cnt;
        logic [PKT_BYTES-2:0][7:0] data;
        logic hold;
        logic rdy;
        logic csum_ok;
    } acbu_rx_s;

    acbu_rx_s s_q;
    acbu_rx_s s_d;

    // No inter-byte timeout: a lost byte shifts framing until the next reset
    always_comb begin
        s_d = s_q;
        if (s_q.hold) begin
            if (take_i) s_d.hold = 1'b0;
        end else if (byte_valid_i) begin
            if (s_q.cnt == 4'(PKT_BYTES-1)) begin
                s_d.csum_ok = (acbu_csum(s_q.data) == byte_i);
                s_d.hold = 1'b1;
                s_d.cnt = '0;
            end else begin
                s_d.data[s_q.cnt[$clog2(PKT_BYTES-1)-1:0]] = byte_i;
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
        s_d.rdy = ~s_d.hold;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ready_o = s_q.rdy;
    assign pkt_valid_o = s_q.hold;
    assign csum_ok_o = s_q.csum_ok;
    assign addr_o = s_q.data[0];
    assign pkt_o = {s_q.data[1], s_q.data[2], s_q.data[3],
                    s_q.data[4], s_q.data[5], s_q.data[6], s_q.data[7]};
endmodule

// [hw/acbu_top.sv]
// Top: command decoder with accumulator, compare flags, branch, APB slave and interrupt
// How it works
// - Reading bank 1 port 0 returns the analog channel as an unsigned value 0 to 65535.
// - Reading bank 2 ports 0 to 7 returns the driven state 0 or 1 of that output line.
// - Code 19 combines the accumulator with the operand and stores the result back.
// - The type selects add, sub, mul, div, mod, and, or, xor, invert or load.
// - A direct arithmetic command is answered with status 100 and an unspecified value; a zero divisor or an unknown type is answered with status 4.
// - The arithmetic command is executed from the host as well as from the program.
// - Code 20 compares accumulator and operand, sets the flags, keeps the accumulator.
// - Code 21 loads the program counter with the value when the condition holds.
// - Conditions 0 to 7 test zero, not zero, eq, ne, gt, ge, lt, le of the last compare.
// - Conditions 8 to 11 test the timeout, alarm, deviation and position error flags.
// - In a program a read also loads the accumulator; from the host it does not.
// - Digital reads give 0 or 1 and the analog read gives a 16-bit result.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module acbu_top import acbu_pkg::*; #(
    parameter int PROG_DEPTH = 16,
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR = 8'h02
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire acbu_apb_req_s apb_i,
    output acbu_apb_rsp_s apb_o,
    output logic irq_o,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_byte_i,
    output logic cmd_ready_o,
    output logic reply_valid_o,
    output logic [7:0] reply_byte_o,
    input wire logic [ADC_W-1:0] analog_input_channel_i,
    input wire logic [OUT_PORTS-1:0] out_state_i,
    input wire acbu_err_s err_flags_i
);
    localparam int PC_W = $clog2(PROG_DEPTH);

    typedef struct packed {
        acbu_st_e st;
        logic [31:0] acc;
        acbu_flags_s flags;
        logic run;
        logic [PC_W-1:0] pc;
        acbu_cmd_s [PROG_DEPTH-1:0] mem;
        logic [PC_W-1:0] prog_addr;
        logic [PROG_CMD_W-1:0] prog_cmd;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [PKT_BYTES*BYTE_W-1:0] rpl;
        logic [3:0] rpl_cnt;
        logic rpl_valid;
        logic [7:0] rpl_byte;
        acbu_apb_rsp_s apb;
    } acbu_top_s;

    acbu_top_s s_q;
    acbu_top_s s_d;
    logic pkt_valid;
    acbu_cmd_s pkt;
    logic [7:0] pkt_addr;
    logic csum_ok;
    logic take;
    acbu_cmd_s exe_cmd;
    logic [31:0] alu_res;
    logic alu_ok;
    acbu_flags_s alu_flags;
    logic rd_ok;
    logic [31:0] rd_val;
    logic dir_go;
    logic prog_go;
    logic cond_ok;
    logic [PC_W-1:0] jmp_tgt;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic wr_en;
    logic [7:0] status;
    logic [31:0] value;

    function automatic logic acbu_mapped(input logic [11:0] a);
        case (a)
            REG_CTRL, REG_STATUS, REG_ACC, REG_IRQ_STAT, REG_IRQ_MASK,
            REG_PROG_ADDR, REG_PROG_CMD, REG_PROG_VAL: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic acbu_cond(input logic [7:0] c, input acbu_flags_s f,
                                       input acbu_err_s e);
        case (c)
            COND_ZE, COND_EQ: return f.eq;
            COND_NZ, COND_NE: return ~f.eq;
            COND_GT: return f.gt;
            COND_GE: return f.gt | f.eq;
            COND_LT: return f.lt;
            COND_LE: return f.lt | f.eq;
            COND_TIMEOUT: return e.timeout_error_flag;
            COND_ALARM: return e.external_alarm_flag;
            COND_DEVIATION: return e.deviation_error_flag;
            COND_POSITION: return e.position_error_flag;
            default: return 1'b0;
        endcase
    endfunction

    acbu_pkt_rx u_rx (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .byte_valid_i(cmd_valid_i),
        .byte_i(cmd_byte_i),
        .take_i(take),
        .ready_o(cmd_ready_o),
        .pkt_valid_o(pkt_valid),
        .addr_o(pkt_addr),
        .pkt_o(pkt),
        .csum_ok_o(csum_ok)
    );

    // Host packets take the shared datapath ahead of the stored program
    assign exe_cmd = pkt_valid ? pkt : s_q.mem[s_q.pc];

    acbu_alu u_alu (
        .acc_i(s_q.acc),
        .opd_i(exe_cmd.value),
        .op_i(exe_cmd.kind),
        .res_o(alu_res),
        .ok_o(alu_ok),
        .flags_o(alu_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        ev = '0;
        clr = '0;
        status = STAT_OK;
        value = s_q.acc;
        rd_ok = 1'b0;
        rd_val = '0;
        if (exe_cmd.bank == BANK_ANALOG && exe_cmd.kind == PORT_ANALOG) begin
            rd_ok = 1'b1;
            rd_val = 32'(analog_input_channel_i);
        end else if (exe_cmd.bank == BANK_OUT_STATE && exe_cmd.kind < 8'(OUT_PORTS)) begin
            rd_ok = 1'b1;
            rd_val = 32'(out_state_i[exe_cmd.kind[$clog2(OUT_PORTS)-1:0]]);
        end
        take = (s_q.st == ACBU_IDLE) & pkt_valid;
        dir_go = take & (pkt_addr == MODULE_ADDR) & csum_ok;
        prog_go = (s_q.st == ACBU_IDLE) & ~pkt_valid & s_q.run;
        cond_ok = acbu_cond(exe_cmd.kind, s_q.flags, err_flags_i);
        jmp_tgt = exe_cmd.value[PC_W-1:0];

        // Direct mode: execute and build the reply
        if (take && pkt_addr == MODULE_ADDR) begin
            if (!csum_ok) begin
                status = STAT_BAD_CSUM;
                ev[IRQ_CSUM] = 1'b1;
            end else begin
                case (pkt.instr)
                    OP_INPUT_READ: begin
                        value = rd_val;
                        if (!rd_ok) status = STAT_BAD_VALUE;
                    end
                    OP_ARITH: begin
                        if (alu_ok) begin
                            s_d.acc = alu_res;
                            value = alu_res;
                        end else begin
                            status = STAT_BAD_VALUE;
                        end
                    end
                    OP_COMPARE: s_d.flags = alu_flags;
                    default: status = STAT_BAD_CMD;
                endcase
            end
            s_d.rpl = {HOST_ADDR, MODULE_ADDR, status, pkt.instr, value,
                       acbu_csum({HOST_ADDR, MODULE_ADDR, status, pkt.instr, value})};
            s_d.st = ACBU_REPLY;
        end

        // Standalone mode: one stored command per idle cycle
        if (prog_go) begin
            case (exe_cmd.instr)
                OP_INPUT_READ: begin
                    if (rd_ok) s_d.acc = rd_val;
                end
                OP_ARITH: begin
                    if (alu_ok) s_d.acc = alu_res;
                end
                OP_COMPARE: s_d.flags = alu_flags;
                default: ;
            endcase
            if (exe_cmd.instr == OP_COND_JUMP && cond_ok) begin
                s_d.pc = jmp_tgt;
                ev[IRQ_JUMP] = 1'b1;
            end else if (s_q.pc == PC_W'(PROG_DEPTH-1)) begin
                s_d.run = 1'b0;
                s_d.pc = '0;
                ev[IRQ_END] = 1'b1;
            end else begin
                s_d.pc = s_q.pc + 1'b1;
            end
        end

        // Reply shifter, one byte per cycle, most significant first
        s_d.rpl_valid = 1'b0;
        if (s_q.st == ACBU_REPLY) begin
            s_d.rpl_valid = 1'b1;
            s_d.rpl_byte = s_q.rpl[PKT_BYTES*BYTE_W-1 -: BYTE_W];
            s_d.rpl = s_q.rpl << BYTE_W;
            s_d.rpl_cnt = s_q.rpl_cnt + 1'b1;
            if (s_q.rpl_cnt == 4'(PKT_BYTES-1)) begin
                s_d.rpl_cnt = '0;
                s_d.st = ACBU_IDLE;
                ev[IRQ_DONE] = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////////
        // APB slave: one wait state, so pready comes from a flop
        wr_en = apb_i.psel & apb_i.penable & s_q.apb.pready & apb_i.pwrite;
        s_d.apb.pready = apb_i.psel & apb_i.penable & ~s_q.apb.pready;
        s_d.apb.pslverr = s_d.apb.pready & ~acbu_mapped(apb_i.paddr);
        s_d.apb.prdata = '0;
        if (s_d.apb.pready && !apb_i.pwrite) begin
            case (apb_i.paddr)
                REG_CTRL: s_d.apb.prdata = 32'(s_q.run) << CTRL_RUN_BIT;
                REG_STATUS: s_d.apb.prdata = (32'(s_q.run) << ST_RUN_BIT)
                    | (32'(s_q.pc) << ST_PC_LSB) | (32'(s_q.flags) << ST_FLAG_LSB);
                REG_ACC: s_d.apb.prdata = s_q.acc;
                REG_IRQ_STAT: s_d.apb.prdata = 32'(s_q.irq_stat);
                REG_IRQ_MASK: s_d.apb.prdata = 32'(s_q.irq_mask);
                REG_PROG_ADDR: s_d.apb.prdata = 32'(s_q.prog_addr);
                REG_PROG_CMD: s_d.apb.prdata = 32'(s_q.prog_cmd);
                default: s_d.apb.prdata = '0;
            endcase
        end
        // Software wins over the program on run and pc
        if (wr_en) begin
            case (apb_i.paddr)
                REG_CTRL: begin
                    if (apb_i.pwdata[CTRL_RUN_BIT] && !s_q.run) s_d.pc = '0;
                    s_d.run = apb_i.pwdata[CTRL_RUN_BIT];
                end
                REG_IRQ_STAT: clr = apb_i.pwdata[IRQ_W-1:0];
                REG_IRQ_MASK: s_d.irq_mask = apb_i.pwdata[IRQ_W-1:0];
                REG_PROG_ADDR: s_d.prog_addr = apb_i.pwdata[PC_W-1:0];
                REG_PROG_CMD: s_d.prog_cmd = apb_i.pwdata[PROG_CMD_W-1:0];
                REG_PROG_VAL: begin
                    s_d.mem[s_q.prog_addr] = {s_q.prog_cmd, apb_i.pwdata};
                    s_d.prog_addr = s_q.prog_addr + 1'b1;
                end
                default: ;
            endcase
        end

        // A new event beats a clear in the same cycle
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_o = s_q.apb;
    assign irq_o = s_q.irq;
    assign reply_valid_o = s_q.rpl_valid;
    assign reply_byte_o = s_q.rpl_byte;

    ////////////////////////////////////////////////////////////////////////////////
    logic exp_bit_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            exp_bit_q <= 1'b0;
        end else if (take) begin
            exp_bit_q <= out_state_i[pkt.kind[$clog2(OUT_PORTS)-1:0]];
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    out_state_reply_a: assert property (dir_go && pkt.instr == OP_INPUT_READ
        && pkt.bank == BANK_OUT_STATE && pkt.kind < 8'(OUT_PORTS)
        |-> ##9 reply_valid_o && reply_byte_o == {7'h00, exp_bit_q})
        else $error("output state byte wrong in reply");
    analog_prog_read_a: assert property (prog_go && exe_cmd.instr == OP_INPUT_READ
        && exe_cmd.bank == BANK_ANALOG && exe_cmd.kind == PORT_ANALOG
        |=> s_q.acc == 32'($past(analog_input_channel_i)))
        else $error("analog value not loaded into accumulator");
    load_operand_a: assert property ((dir_go || prog_go) && exe_cmd.instr == OP_ARITH
        && exe_cmd.kind == ALU_LOAD |=> s_q.acc == $past(exe_cmd.value))
        else $error("load did not reach accumulator");
    direct_add_a: assert property (dir_go && pkt.instr == OP_ARITH
        && pkt.kind == ALU_ADD |=> s_q.acc == $past(s_q.acc) + $past(pkt.value))
        else $error("direct add result wrong");
    arith_status_a: assert property (dir_go && pkt.instr == OP_ARITH && alu_ok
        |-> ##4 reply_valid_o && reply_byte_o == STAT_OK)
        else $error("arithmetic reply status not ok");
    compare_keeps_acc_a: assert property ((dir_go || prog_go)
        && exe_cmd.instr == OP_COMPARE |=> $stable(s_q.acc)
        && s_q.flags.gt == ($signed($past(s_q.acc)) > $signed($past(exe_cmd.value))))
        else $error("compare changed accumulator or flags wrong");
    jump_taken_a: assert property (prog_go && exe_cmd.instr == OP_COND_JUMP
        && cond_ok |=> s_q.pc == $past(jmp_tgt) && s_q.irq_stat[IRQ_JUMP])
        else $error("conditional jump not taken");
    jump_equal_a: assert property (prog_go && exe_cmd.instr == OP_COND_JUMP
        && (exe_cmd.kind == COND_EQ && !s_q.flags.eq || exe_cmd.kind == COND_NE && s_q.flags.eq)
        && s_q.pc != PC_W'(PROG_DEPTH-1)
        |=> s_q.pc == $past(s_q.pc) + 1'b1)
        else $error("equality jump taken against the flag");
    timeout_jump_a: assert property (prog_go && exe_cmd.instr == OP_COND_JUMP
        && exe_cmd.kind == COND_TIMEOUT && err_flags_i.timeout_error_flag
        |=> s_q.pc == $past(jmp_tgt))
        else $error("timeout jump not taken");
    direct_jump_refused_a: assert property (dir_go && pkt.instr == OP_COND_JUMP
        |=> $stable(s_q.pc) ##3 reply_byte_o == STAT_BAD_CMD)
        else $error("direct conditional jump not refused");
    direct_read_acc_a: assert property (dir_go && pkt.instr == OP_INPUT_READ
        |=> $stable(s_q.acc))
        else $error("direct read touched accumulator");
    bad_csum_a: assert property (take && pkt_addr == MODULE_ADDR && !csum_ok
        |-> ##4 reply_byte_o == STAT_BAD_CSUM)
        else $error("bad checksum not reported");

    direct_arith_c: cover property (dir_go && pkt.instr == OP_ARITH ##4 reply_valid_o);
    prog_jump_c: cover property (prog_go && exe_cmd.instr == OP_COND_JUMP && cond_ok);
    bad_csum_c: cover property (take && !csum_ok);
    prog_end_c: cover property (s_q.run ##1 !s_q.run && s_q.irq_stat[IRQ_END]);
endmodule

// [dv/acbu_host_model.sv]
// Host model: streams command packets into the receiver
`timescale 1ns/1ps
module acbu_host_model (
    input wire logic clk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [7:0] byte_o
);
    initial begin
        valid_o = 1'b0;
        byte_o = 8'h00;
    end
    // Body is address, instr, type, bank, value; bad corrupts the sum
    task automatic send(input logic [63:0] b, input logic bad);
        logic [7:0] s;
        s = {7'h0, bad};
        for (int i = 0; i < 8; i++) s = s + b[i*8+:8];
        for (int i = 8; i >= 0; i--) begin
            valid_o <= 1'b1;
            byte_o <= (i == 0) ? s : b[(i-1)*8+:8];
            do @(posedge clk_i); while (ready_i !== 1'b1);
        end
        valid_o <= 1'b0;
        // Released line must not keep the last byte
        byte_o <= ~byte_o;
        @(posedge clk_i);
    endtask
endmodule

// [dv/accumulator_compare_branch_unit_tb.sv]
// Bench: host packets, register checks and a stored program
`timescale 1ns/1ps
module accumulator_compare_branch_unit_tb import acbu_pkg::*; ;
    localparam logic [71:0] ALL = '1;
    // Arithmetic reply value is undefined, so only header bytes count
    localparam logic [71:0] TOP = {32'hffffffff, 40'h0};
    logic clk_sys_i, arst_n_i, cmd_valid_i, cmd_ready_o, reply_valid_o, irq_o;
    logic [7:0] cmd_byte_i, reply_byte_o, ost;
    logic [15:0] ain;
    acbu_err_s errf;
    acbu_apb_req_s req;
    acbu_apb_rsp_s rsp;
    logic [71:0] exp_q[$], msk_q[$], got, e, m;
    logic [31:0] acc, opd, r;
    logic slv;
    int err_total, comparisons, nb;
    logic [31:0] prog[8] = '{{OP_ARITH, ALU_LOAD, 16'h07}, {OP_COMPARE, 24'h07},
        {OP_COND_JUMP, COND_EQ, 16'h04}, {OP_ARITH, ALU_LOAD, 16'h63},
        {OP_COND_JUMP, COND_TIMEOUT, 16'h06}, {OP_ARITH, ALU_LOAD, 16'h37},
        {OP_COND_JUMP, COND_NE, 16'h00}, {OP_ARITH, ALU_ADD, 16'h01}};
    acbu_top uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .apb_i(req), .apb_o(rsp),
        .irq_o(irq_o), .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i),
        .cmd_ready_o(cmd_ready_o), .reply_valid_o(reply_valid_o),
        .reply_byte_o(reply_byte_o), .analog_input_channel_i(ain), .out_state_i(ost),
        .err_flags_i(errf));
    acbu_host_model host (.clk_i(clk_sys_i), .ready_i(cmd_ready_o), .valid_o(cmd_valid_i),
        .byte_o(cmd_byte_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [71:0] g, input logic [71:0] x, input logic [71:0] k);
        comparisons++;
        if (((g ^ x) & k) !== 72'h0) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g & k, x & k);
        end
    endtask
    always @(posedge clk_sys_i) begin
        if (reply_valid_o === 1'b1) begin
            got = {got[63:0], reply_byte_o};
            nb++;
            if (nb == 9) begin
                nb = 0;
                e = exp_q.pop_front();
                m = msk_q.pop_front();
                chk(got, e, m);
            end
        end
    end
    task automatic cmd(input logic [7:0] i, t, b, input logic [31:0] v, input logic [7:0] st,
        input logic [31:0] rv, input logic bad, input logic [71:0] k);
        logic [7:0] s;
        logic [71:0] x;
        x = {8'h02, 8'h01, st, i, rv, 8'h00};
        s = 8'h00;
        for (int j = 1; j < 9; j++) s = s + x[j*8+:8];
        x[7:0] = s;
        exp_q.push_back(x);
        msk_q.push_back(k);
        host.send({8'h01, i, t, b, v}, bad);
        for (int j = 0; j < 60 && exp_q.size() != 0; j++) @(posedge clk_sys_i);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        do @(posedge clk_sys_i); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        slv = rsp.pslverr;
        req <= '0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] k);
        apb(1'b0, a, 32'h0);
        chk({40'h0, r}, {40'h0, x}, {40'h0, k});
    endtask
    function automatic logic [31:0] alu(input logic signed [31:0] a, b, input int k);
        case (k)
            0: return a + b;
            1: return a - b;
            2: return a * b;
            3: return a / b;
            4: return a % b;
            5: return a & b;
            6: return a | b;
            7: return a ^ b;
            8: return ~a;
            default: return b;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n_i = 1'b0;
        req = '0;
        ain = 16'h0;
        ost = 8'h0;
        errf = '0;
        r = $urandom(32'h7431e478);
        repeat (16) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        ain <= 16'($urandom);
        ost <= 8'($urandom);
        repeat (2) @(posedge clk_sys_i);
        for (int p = 0; p < 8; p++) begin
            cmd(OP_INPUT_READ, 8'(p), BANK_OUT_STATE, 0, STAT_OK, {31'h0, ost[p]}, 0, ALL);
        end
        for (int j = 0; j < 10; j++) begin
            opd = j[0] ? 32'(-$urandom_range(1, 99)) : 32'($urandom_range(1, 999));
            acc = alu(acc, opd, (j + 9) % 10);
            cmd(OP_ARITH, 8'((j + 9) % 10), 0, opd, STAT_OK, acc, 0, TOP);
            rd(REG_ACC, acc, '1);
        end
        cmd(OP_INPUT_READ, PORT_ANALOG, BANK_ANALOG, 0, STAT_OK, {16'h0, ain}, 0, ALL);
        rd(REG_ACC, acc, '1);
        cmd(OP_COMPARE, 0, 0, acc - 1, STAT_OK, acc, 0, ALL);
        rd(REG_ACC, acc, '1);
        rd(REG_STATUS, 32'h0002_0000, 32'h0007_0000);
        cmd(OP_COND_JUMP, COND_EQ, 0, 0, STAT_BAD_CMD, acc, 0, ALL);
        apb(1, REG_IRQ_MASK, 32'h2);
        cmd(OP_ARITH, ALU_ADD, 0, 1, STAT_BAD_CSUM, acc, 1, {24'hffffff, 48'h0});
        repeat (3) @(posedge clk_sys_i);
        chk(irq_o, 1, 1);
        apb(1, REG_IRQ_STAT, 32'h2);
        repeat (2) @(posedge clk_sys_i);
        chk(irq_o, 0, 1);
        errf <= '{timeout_error_flag: 1'b1, default: 1'b0};
        apb(1, REG_PROG_ADDR, 0);
        for (int j = 0; j < 8; j++) begin
            apb(1, REG_PROG_CMD, prog[j][31:8]);
            apb(1, REG_PROG_VAL, {24'h0, prog[j][7:0]});
        end
        apb(1, REG_IRQ_MASK, 32'h4);
        apb(1, REG_CTRL, 1);
        for (int j = 0; j < 200 && irq_o !== 1'b1; j++) @(posedge clk_sys_i);
        rd(REG_ACC, 32'd8, '1);
        rd(REG_IRQ_STAT, 32'hc, 32'hc);
        // Second run appends a stored analog read after the add
        apb(1, REG_PROG_ADDR, 8);
        apb(1, REG_PROG_CMD, {OP_INPUT_READ, PORT_ANALOG, BANK_ANALOG});
        apb(1, REG_PROG_VAL, 0);
        apb(1, REG_IRQ_STAT, 32'hc);
        apb(1, REG_CTRL, 1);
        for (int j = 0; j < 200 && irq_o !== 1'b1; j++) @(posedge clk_sys_i);
        rd(REG_ACC, {16'h0, ain}, '1);
        rd(12'h020, 32'h0, '1);
        chk(slv, 1, 1);
        chk(exp_q.size(), 0, '1);
        summarize();
    end
endmodule
